// ==== tb/ssp_master_model.sv ====
// Behavioural synchronous master that makes the shift clock for the port.
// Assumes the bench resolves the shared data wire and calls xfer in turn.
`timescale 1ns/10ps
module ssp_master_model (
    output logic      ck,
    output logic      dt_drv,
    input  wire logic dt_wire
);
    // ************************************************************
    // Frame engine
    // ************************************************************
    logic idle_lvl;

    initial begin
        ck       = 1'b0;
        dt_drv   = 1'b0;
        idle_lvl = 1'b0;
    end

    // Only change the idle level while the port is off: it is an edge.
    task automatic set_idle(input logic lvl);
        idle_lvl = lvl;
        ck       = lvl;
        #200;
    endtask

    // The clock stands at its idle level between frames.
    // Only data bits are clocked.
    // A long non-idle phase gives the slave time to present each bit.
    task automatic xfer(input int n, input logic [8:0] send,
                        output logic [8:0] got);
        got = 9'h000;
        for (int i = 0; i < n; i++) begin
            ck     = ~idle_lvl;
            dt_drv = send[i];
            #140;
            ck     = idle_lvl;
            got[i] = dt_wire;
            #60;
        end
        // A released line must not keep showing the last bit.
        dt_drv = ~dt_drv;
        #400;
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the synchronous slave port.
// Assumes the master model on the link and a plain register port.
`timescale 1ns/10ps
module testbench;
    localparam logic [2:0] A_TXC = ssp_pkg::OFF_TX_CTRL;
    localparam logic [2:0] A_RXC = ssp_pkg::OFF_RX_CTRL;
    localparam logic [2:0] A_BDC = ssp_pkg::OFF_BAUD;
    localparam logic [2:0] A_RXD = ssp_pkg::OFF_RX_DATA;
    localparam logic [2:0] A_TXD = ssp_pkg::OFF_TX_DATA;
    localparam logic [2:0] A_IRC = ssp_pkg::OFF_IRQ_CTRL;
    logic                     core_clk;
    logic                     nrst;
    ssp_pkg::ssp_bus_req_type bus_req;
    logic [7:0]               bus_rdata;
    ssp_pkg::ssp_pin_out_type pins_out;
    logic                     wake_req;
    logic                     irq_out;
    logic                     m_ck;
    logic                     m_dt;
    logic                     dt_wire;
    logic [8:0]               got;
    logic [7:0]               rv;
    logic [16:0]              cfg [7];
    int                       err_count;
    int                       checked;

    assign dt_wire = pins_out.dt_oe ? pins_out.dt_out : m_dt;

    ssp_core #(.FIFO_DEPTH(2)) i_ssp_core (
        .core_clk            (core_clk),
        .nrst                (nrst),
        .bus_req             (bus_req),
        .bus_rdata           (bus_rdata),
        .serial_clock_pin_in (m_ck),
        .serial_data_pin_in  (dt_wire),
        .pins_out            (pins_out),
        .wake_req            (wake_req),
        .irq_out             (irq_out)
    );

    ssp_master_model i_ssp_master_model (
        .ck      (m_ck),
        .dt_drv  (m_dt),
        .dt_wire (dt_wire)
    );

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h, expected %h", $time, seen,
                     exp);
        end
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        rv = bus_rdata;
        chk({1'b0, rv}, {1'b0, exp});
    endtask

    task automatic frame(input int n, input logic [8:0] v);
        i_ssp_master_model.xfer(n, v, got);
        repeat (10) @(posedge core_clk);
    endtask

    task automatic end_sim();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #500000;
        err_count++;
        end_sim();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        nrst    = 1'b0;
        bus_req = '0;
        cfg = '{17'h1_3080, 17'h0_1080, 17'h0_3000, 17'h0_3090,
                17'h0_30a0, 17'h0_b080, 17'h0_2080};
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        rchk(A_RXC, 8'h00);
        rchk(A_TXD, 8'h00);
        rchk(A_IRC, 8'h01);
        wr(A_BDC, 8'hff);
        rchk(A_BDC, 8'h5b);
        wr(A_BDC, 8'h00);
        for (int i = 0; i < 7; i++) begin
            wr(A_TXC, cfg[i][15:8]);
            wr(A_RXC, cfg[i][7:0]);
            // The mode register lags the control write by one cycle.
            @(posedge core_clk);
            #1;
            chk({5'h00, pins_out}, {8'h00, cfg[i][16]});
        end
        wr(A_TXC, 8'h30);
        wr(A_RXC, 8'h80);
        wr(A_IRC, 8'h50);
        wr(A_TXD, 8'ha5);
        wr(A_TXD, 8'h3c);
        rchk(A_IRC, 8'h50);
        chk({7'h00, wake_req, irq_out}, 9'h000);
        frame(8, 9'h000);
        chk(got, 9'h0a5);
        rchk(A_IRC, 8'h51);
        chk({7'h00, wake_req, irq_out}, 9'h002);
        frame(8, 9'h000);
        chk(got, 9'h03c);
        wr(A_TXC, 8'h71);
        wr(A_TXD, 8'h5a);
        wr(A_IRC, 8'hd0);
        frame(9, 9'h000);
        chk(got, 9'h15a);
        chk({7'h00, wake_req, irq_out}, 9'h003);
        wr(A_TXC, 8'h10);
        wr(A_RXC, 8'h90);
        wr(A_IRC, 8'h20);
        frame(8, 9'h096);
        rchk(A_IRC, 8'h23);
        chk({7'h00, wake_req, irq_out}, 9'h002);
        rchk(A_RXD, 8'h96);
        rchk(A_IRC, 8'h21);
        wr(A_RXC, 8'hd0);
        frame(9, 9'h13c);
        rchk(A_RXC, 8'hd1);
        rchk(A_RXD, 8'h3c);
        wr(A_RXC, 8'h90);
        frame(8, 9'h011);
        frame(8, 9'h022);
        frame(8, 9'h033);
        rchk(A_RXC, 8'h92);
        rchk(A_RXD, 8'h11);
        rchk(A_RXD, 8'h22);
        frame(8, 9'h044);
        rchk(A_IRC, 8'h21);
        wr(A_RXC, 8'h80);
        rchk(A_RXC, 8'h80);
        wr(A_RXC, 8'h90);
        frame(8, 9'h055);
        rchk(A_RXD, 8'h55);
        wr(A_RXC, 8'h00);
        wr(A_BDC, 8'h10);
        i_ssp_master_model.set_idle(1'b1);
        wr(A_RXC, 8'h90);
        frame(8, 9'h066);
        rchk(A_RXD, 8'h66);
        end_sim();
    end
endmodule

// ==== verilog/ssp_core.sv ====
// Synchronous slave serial port: registers, transmit and receive shifting.
// Assumes the shift clock and data pins are asynchronous to core_clk and
// that the link clock is at most one eighth of the core clock.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ssp_core #(
    parameter int FIFO_DEPTH = 2
) (
    input  wire logic                     core_clk,
    input  wire logic                     nrst,
    input  wire ssp_pkg::ssp_bus_req_type bus_req,
    output logic [7:0]                    bus_rdata,
    input  wire logic                     serial_clock_pin_in,
    input  wire logic                     serial_data_pin_in,
    output ssp_pkg::ssp_pin_out_type      pins_out,
    output logic                          wake_req,
    output logic                          irq_out
);

    // ************************************************************
    // State
    // ************************************************************
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FIFO_DEPTH);

    if (FIFO_DEPTH < 1 || FIFO_DEPTH > 8) begin : g_depth_check
        $error("FIFO_DEPTH must lie between 1 and 8.");
    end

    typedef struct packed {
        logic                         ck_s1;
        logic                         ck_s2;
        logic                         ck_s3;
        logic                         dt_s1;
        logic                         dt_s2;
        logic [7:0]                   tx_ctrl;
        logic [7:0]                   rx_ctrl;
        logic [7:0]                   baud;
        logic [7:0]                   brg_lo;
        logic [7:0]                   brg_hi;
        logic [7:0]                   irqen;
        ssp_pkg::ssp_mode_type        mode;
        logic [8:0]                   hold;
        logic                         hold_valid;
        logic [8:0]                   tx_shift;
        logic                         tx_busy;
        logic [3:0]                   tx_cnt;
        logic                         dout;
        logic [8:0]                   rx_shift;
        logic [3:0]                   rx_cnt;
        logic [FIFO_DEPTH-1:0][8:0]   fifo;
        logic [CNT_W-1:0]             fifo_cnt;
        logic                         overrun;
        logic [7:0]                   rdata;
        logic                         wake;
        logic                         irq;
    } ssp_state_type;

    localparam ssp_state_type ST_RESET = '0;

    ssp_state_type st_reg;
    ssp_state_type st_next;

    function automatic logic [3:0] char_bits(input logic ninth);
        char_bits = ninth ? ssp_pkg::BITS_NINE : ssp_pkg::BITS_EIGHT;
    endfunction

    function automatic ssp_pkg::ssp_mode_type decode_mode(
        input logic [7:0] tx,
        input logic [7:0] rc
    );
        if (!rc[ssp_pkg::RC_PORT_EN] || !tx[ssp_pkg::TX_SYNC]
            || tx[ssp_pkg::TX_MASTER]) begin
            decode_mode = ssp_pkg::SSP_MODE_OFF;
        end else if (rc[ssp_pkg::RC_SINGLE] || rc[ssp_pkg::RC_CONT]) begin
            decode_mode = ssp_pkg::SSP_MODE_RX;
        end else begin
            decode_mode = ssp_pkg::SSP_MODE_TX;
        end
    endfunction

    // ************************************************************
    // Helpers
    // ************************************************************
    logic       clk_rise;
    logic       clk_fall;
    logic       lead_edge;
    logic       trail_edge;
    logic       tx_run;
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    logic       tx_buffer_empty_flag;
    logic       rx_ready_flag;
    logic       pop;
    logic       rx_done;
    logic [8:0] rx_char;
    logic [8:0] rx_shifted;
    logic [7:0] rd_val;

    assign clk_rise   = st_reg.ck_s2 & ~st_reg.ck_s3;
    assign clk_fall   = ~st_reg.ck_s2 & st_reg.ck_s3;
    // Clock polarity select swaps which edge leads.
    assign lead_edge  = st_reg.baud[ssp_pkg::BD_SCKP] ? clk_fall : clk_rise;
    assign trail_edge = st_reg.baud[ssp_pkg::BD_SCKP] ? clk_rise : clk_fall;
    assign tx_run     = (st_reg.mode == ssp_pkg::SSP_MODE_TX)
                        && st_reg.tx_ctrl[ssp_pkg::TX_ENABLE];
    assign tx_bits    = char_bits(st_reg.tx_ctrl[ssp_pkg::TX_NINTH_MODE]);
    assign rx_bits    = char_bits(st_reg.rx_ctrl[ssp_pkg::RC_NINTH_MODE]);
    assign tx_buffer_empty_flag = ~st_reg.hold_valid;
    assign rx_ready_flag        = st_reg.fifo_cnt != '0;
    assign pop = bus_req.rd && bus_req.addr == ssp_pkg::OFF_RX_DATA
                 && rx_ready_flag;
    assign rx_shifted = {st_reg.dt_s2, st_reg.rx_shift[8:1]};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        rx_done = 1'b0;
        rx_char = 9'h000;
        rd_val  = ssp_pkg::REG_RESET;
        // Pins pass two flops before any edge logic looks at them.
        st_next.ck_s1 = serial_clock_pin_in;
        st_next.ck_s2 = st_reg.ck_s1;
        st_next.ck_s3 = st_reg.ck_s2;
        st_next.dt_s1 = serial_data_pin_in;
        st_next.dt_s2 = st_reg.dt_s1;
        st_next.mode  = decode_mode(st_reg.tx_ctrl,
                                    st_reg.rx_ctrl);

        case (st_reg.mode)
            ssp_pkg::SSP_MODE_TX: begin
                st_next.rx_cnt = 4'h0;
                if (!tx_run) begin
                    st_next.tx_busy = 1'b0;
                    st_next.tx_cnt  = 4'h0;
                end else if (st_reg.tx_busy) begin
                    if (lead_edge) begin
                        st_next.dout = st_reg.tx_shift[0];
                        st_next.tx_shift = {1'b0, st_reg.tx_shift[8:1]};
                    end
                    if (trail_edge) begin
                        if (st_reg.tx_cnt == tx_bits - 4'h1) begin
                            st_next.tx_busy = 1'b0;
                            st_next.tx_cnt  = 4'h0;
                        end else begin
                            st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
                        end
                    end
                end else if (st_reg.hold_valid) begin
                    st_next.tx_shift   = st_reg.hold;
                    st_next.tx_busy    = 1'b1;
                    st_next.tx_cnt     = 4'h0;
                    st_next.hold_valid = 1'b0;
                end
            end
            ssp_pkg::SSP_MODE_RX: begin
                // Receiver never idles here; single enable is ignored.
                st_next.tx_busy = 1'b0;
                st_next.tx_cnt  = 4'h0;
                if (trail_edge) begin
                    st_next.rx_shift = rx_shifted;
                    if (st_reg.rx_cnt == rx_bits - 4'h1) begin
                        rx_done = 1'b1;
                        rx_char = st_reg.rx_ctrl[ssp_pkg::RC_NINTH_MODE]
                                  ? rx_shifted
                                  : {1'b0, rx_shifted[8:1]};
                        st_next.rx_cnt = 4'h0;
                    end else begin
                        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
                    end
                end
            end
            default: begin
                st_next.tx_busy = 1'b0;
                st_next.tx_cnt  = 4'h0;
                st_next.rx_cnt  = 4'h0;
            end
        endcase

        // Pop before push so a read in the completion cycle makes room.
        if (pop) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                st_next.fifo[i] = st_reg.fifo[i+1];
            end
            st_next.fifo_cnt = st_reg.fifo_cnt - CNT_W'(1);
        end
        if (rx_done && !st_reg.overrun) begin
            if (st_next.fifo_cnt == FULL_CNT) begin
                st_next.overrun = 1'b1;
            end else begin
                st_next.fifo[st_next.fifo_cnt] = rx_char;
                st_next.fifo_cnt = st_next.fifo_cnt + CNT_W'(1);
            end
        end
        // Overrun only lives while continuous receive is on.
        if (!st_reg.rx_ctrl[ssp_pkg::RC_CONT]) begin
            st_next.overrun = 1'b0;
        end

        if (bus_req.wr) begin
            case (bus_req.addr)
                ssp_pkg::OFF_TX_CTRL:
                    st_next.tx_ctrl = bus_req.wdata & ssp_pkg::TX_CTRL_WMASK;
                ssp_pkg::OFF_RX_CTRL:
                    st_next.rx_ctrl = bus_req.wdata & ssp_pkg::RX_CTRL_WMASK;
                ssp_pkg::OFF_BAUD:
                    st_next.baud = bus_req.wdata & ssp_pkg::BAUD_WMASK;
                ssp_pkg::OFF_BRG_LO:
                    st_next.brg_lo = bus_req.wdata;
                ssp_pkg::OFF_BRG_HI:
                    st_next.brg_hi = bus_req.wdata;
                ssp_pkg::OFF_IRQ_CTRL:
                    st_next.irqen = bus_req.wdata & ssp_pkg::IRQ_WMASK;
                ssp_pkg::OFF_TX_DATA: begin
                    // Ninth bit is taken as it stands at the data write.
                    st_next.hold = {st_reg.tx_ctrl[ssp_pkg::TX_NINTH_VAL],
                                    bus_req.wdata};
                    st_next.hold_valid = 1'b1;
                end
                default: ;
            endcase
        end

        if (bus_req.rd) begin
            case (bus_req.addr)
                ssp_pkg::OFF_TX_CTRL: begin
                    rd_val = st_reg.tx_ctrl;
                    rd_val[ssp_pkg::TX_TRMT] = ~st_reg.tx_busy;
                end
                ssp_pkg::OFF_RX_CTRL: begin
                    rd_val = st_reg.rx_ctrl;
                    rd_val[ssp_pkg::RC_OVERRUN] = st_reg.overrun;
                    rd_val[ssp_pkg::RC_NINTH_VAL] = rx_ready_flag
                        && st_reg.rx_ctrl[ssp_pkg::RC_NINTH_MODE]
                        && st_reg.fifo[0][8];
                end
                ssp_pkg::OFF_BAUD: begin
                    rd_val = st_reg.baud;
                    rd_val[ssp_pkg::BD_RCIDL] = st_reg.rx_cnt == 4'h0;
                end
                ssp_pkg::OFF_RX_DATA:
                    rd_val = rx_ready_flag ? st_reg.fifo[0][7:0]
                                           : ssp_pkg::REG_RESET;
                ssp_pkg::OFF_BRG_LO: rd_val = st_reg.brg_lo;
                ssp_pkg::OFF_BRG_HI: rd_val = st_reg.brg_hi;
                ssp_pkg::OFF_IRQ_CTRL: begin
                    rd_val = st_reg.irqen;
                    rd_val[ssp_pkg::IE_RX_READY] = rx_ready_flag;
                    rd_val[ssp_pkg::IE_TX_EMPTY] = tx_buffer_empty_flag;
                end
                default: rd_val = ssp_pkg::REG_RESET;
            endcase
        end
        st_next.rdata = rd_val;

        // Clearing the port enable empties the whole serial unit.
        if (!st_reg.rx_ctrl[ssp_pkg::RC_PORT_EN]) begin
            st_next.hold_valid = 1'b0;
            st_next.tx_busy    = 1'b0;
            st_next.rx_cnt     = 4'h0;
            st_next.fifo_cnt   = '0;
            st_next.overrun    = 1'b0;
        end

        // Wake takes one more core clock edge after the flags themselves.
        st_next.wake = (st_reg.irqen[ssp_pkg::IE_PERIPH]
                        && st_reg.irqen[ssp_pkg::IE_TX_EN]
                        && tx_buffer_empty_flag)
                       || (st_reg.irqen[ssp_pkg::IE_RX_EN]
                        && rx_ready_flag);
        st_next.irq = st_next.wake && st_reg.irqen[ssp_pkg::IE_GLOBAL];
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign bus_rdata       = st_reg.rdata;
    assign pins_out.ck_out = 1'b0;
    assign pins_out.ck_oe  = 1'b0;
    assign pins_out.dt_out = st_reg.dout;
    assign pins_out.dt_oe  = tx_run;
    assign wake_req        = st_reg.wake;
    assign irq_out         = st_reg.irq;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_tx_write_idle;
        bus_req.wr && bus_req.addr == ssp_pkg::OFF_TX_DATA
        && !st_reg.hold_valid && !st_reg.tx_busy && tx_run
        ##1 tx_run;
    endsequence

    sequence s_tx_last_bit;
        tx_run && st_reg.tx_busy && trail_edge && st_reg.hold_valid
        && st_reg.tx_cnt == tx_bits - 4'h1
        ##1 tx_run && !(bus_req.wr && bus_req.addr == ssp_pkg::OFF_TX_DATA);
    endsequence

    a_clock_pin_input: assert property (
        !pins_out.ck_oe)
        else $error("Clock pin driven in slave mode.");

    a_first_load: assert property (
        s_tx_write_idle |=> st_reg.tx_busy)
        else $error("Written character did not enter shift register.");

    a_held_flag_low: assert property (
        bus_req.wr && bus_req.addr == ssp_pkg::OFF_TX_DATA
        && st_reg.tx_busy && st_reg.rx_ctrl[ssp_pkg::RC_PORT_EN]
        |=> !tx_buffer_empty_flag)
        else $error("Empty flag high with a character held.");

    a_reload_then_flag: assert property (
        s_tx_last_bit |=> st_reg.tx_busy && tx_buffer_empty_flag)
        else $error("Held character not reloaded after shift-out.");

    a_transmit_enable_gate: assert property (
        !st_reg.tx_ctrl[ssp_pkg::TX_ENABLE] |=> !st_reg.tx_busy)
        else $error("Shifting while transmit disabled.");

    a_lead_shift: assert property (
        tx_run && st_reg.tx_busy && lead_edge
        |=> pins_out.dt_out == $past(st_reg.tx_shift[0]))
        else $error("Wrong bit driven on leading edge.");

    a_rx_ready: assert property (
        rx_done && !st_reg.overrun && st_reg.fifo_cnt != FULL_CNT
        && st_reg.rx_ctrl[ssp_pkg::RC_PORT_EN] |=> rx_ready_flag)
        else $error("Ready flag missing after reception.");

    a_overrun_set: assert property (
        rx_done && !pop && st_reg.fifo_cnt == FULL_CNT
        && st_reg.rx_ctrl[ssp_pkg::RC_CONT]
        && st_reg.rx_ctrl[ssp_pkg::RC_PORT_EN]
        |=> st_reg.overrun && st_reg.fifo_cnt == FULL_CNT)
        else $error("Overrun not flagged or FIFO overwritten.");

    a_overrun_clear: assert property (
        !st_reg.rx_ctrl[ssp_pkg::RC_CONT] |=> !st_reg.overrun)
        else $error("Overrun survived clearing continuous receive.");

    a_read_pop: assert property (
        pop && !rx_done && st_reg.rx_ctrl[ssp_pkg::RC_PORT_EN]
        |=> bus_rdata == $past(st_reg.fifo[0][7:0])
            && st_reg.fifo_cnt == $past(st_reg.fifo_cnt) - CNT_W'(1))
        else $error("Receive read did not return and pop top entry.");

    a_tx_wake: assert property (
        st_reg.irqen[ssp_pkg::IE_PERIPH] && st_reg.irqen[ssp_pkg::IE_TX_EN]
        && tx_buffer_empty_flag |=> wake_req)
        else $error("No wake request on transmit empty.");

    a_port_off: assert property (
        !st_reg.rx_ctrl[ssp_pkg::RC_PORT_EN]
        |=> st_reg.fifo_cnt == '0 && !st_reg.tx_busy && !pins_out.dt_oe)
        else $error("Serial unit active with port disabled.");

endmodule

// ==== verilog/ssp_pkg.sv ====
// Constants, register map and carrier types of the synchronous slave port.
// Assumes one 40 MHz core clock and a register port with 3-bit addresses.
package ssp_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_TX_CTRL  = 3'h0;
    localparam logic [2:0] OFF_RX_CTRL  = 3'h1;
    localparam logic [2:0] OFF_BAUD     = 3'h2;
    localparam logic [2:0] OFF_RX_DATA  = 3'h3;
    localparam logic [2:0] OFF_BRG_LO   = 3'h4;
    localparam logic [2:0] OFF_BRG_HI   = 3'h5;
    localparam logic [2:0] OFF_TX_DATA  = 3'h6;
    localparam logic [2:0] OFF_IRQ_CTRL = 3'h7;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TX_MASTER     = 7;
    localparam int TX_NINTH_MODE = 6;
    localparam int TX_ENABLE     = 5;
    localparam int TX_SYNC       = 4;
    localparam int TX_TRMT       = 1;
    localparam int TX_NINTH_VAL  = 0;
    localparam int RC_PORT_EN    = 7;
    localparam int RC_NINTH_MODE = 6;
    localparam int RC_SINGLE     = 5;
    localparam int RC_CONT       = 4;
    localparam int RC_OVERRUN    = 1;
    localparam int RC_NINTH_VAL  = 0;
    localparam int BD_RCIDL      = 6;
    localparam int BD_SCKP       = 4;
    localparam int IE_GLOBAL     = 7;
    localparam int IE_PERIPH     = 6;
    localparam int IE_RX_EN      = 5;
    localparam int IE_TX_EN      = 4;
    localparam int IE_RX_READY   = 1;
    localparam int IE_TX_EMPTY   = 0;

    // ************************************************************
    // Write masks, reset values and character sizes
    // ************************************************************
    localparam logic [7:0] TX_CTRL_WMASK = 8'hfd;
    localparam logic [7:0] RX_CTRL_WMASK = 8'hf8;
    localparam logic [7:0] BAUD_WMASK  = 8'h1b;
    localparam logic [7:0] IRQ_WMASK   = 8'hf0;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [3:0] BITS_EIGHT  = 4'h8;
    localparam logic [3:0] BITS_NINE   = 4'h9;

    typedef enum logic [1:0] {
        SSP_MODE_OFF = 2'b00,
        SSP_MODE_TX  = 2'b01,
        SSP_MODE_RX  = 2'b10
    } ssp_mode_type;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ssp_bus_req_type;

    typedef struct packed {
        logic ck_out;
        logic ck_oe;
        logic dt_out;
        logic dt_oe;
    } ssp_pin_out_type;

endpackage
